//--- common/ldrb_params.svh
`ifndef LDRB_PARAMS_SVH
`define LDRB_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LDRB_OFF_BRT 8'h00
`define LDRB_OFF_CUR 8'h02
`define LDRB_OFF_USA 8'h04
`define LDRB_OFF_USB 8'h06
`define LDRB_OFF_EN_SUP 8'h08
`define LDRB_OFF_EN_CNV 8'h0A
`define LDRB_OFF_EN_STR 8'h0C
`define LDRB_OFF_ST_SUP 8'h0E
`define LDRB_OFF_ST_CNV 8'h10
`define LDRB_OFF_ST_STR 8'h12
`define LDRB_OFF_STATE 8'h14
`define LDRB_OFF_IN_DUTY 8'h16
`define LDRB_OFF_OUT_DUTY 8'h18
`define LDRB_OFF_CUR_CODE 8'h1A
`define LDRB_OFF_BOOST 8'h1C
`define LDRB_OFF_DETECT 8'h1E
// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define LDRB_RST_BRT 16'h0000
`define LDRB_RST_CUR 16'h0FFF
`define LDRB_RST_USA 16'h08A3
`define LDRB_RST_USB 16'h0000
`define LDRB_RST_EN_SUP 8'hFF
`define LDRB_RST_EN_CNV 8'hFF
`define LDRB_RST_EN_STR 8'h7F
`define LDRB_GDIS_BIT 0
`define LDRB_SRC_REG 2'h2
`define LDRB_EN_DIS 2'h1
`define LDRB_EN_ENA 2'h3
`define LDRB_EN_RD_ON 2'h2
`define LDRB_SLV_BASE 6'h15
`define LDRB_DUTY_WIN 65536
`endif

//--- common/ldrb_pkg.sv
package ldrb_pkg;
	typedef enum logic [5:0] {
		I_IDLE = 6'h01,
		I_ADDR = 6'h02,
		I_ACK = 6'h04,
		I_RX = 6'h08,
		I_TX = 6'h10,
		I_RACK = 6'h20
	} ldrb_i2c_st_t;
	typedef struct packed {
		logic [7:0] sup;
		logic [7:0] cnv;
		logic [7:0] str;
	} ldrb_fault_t;
	typedef struct packed {
		logic [15:0] live_state_readback;
		logic [15:0] output_duty_readback;
		logic [11:0] current_code_readback;
		logic [9:0] boost_target_readback;
		logic [2:0] detected_dim_mode;
		logic [2:0] detected_phase_setting;
		logic [2:0] detected_switch_rate;
		logic [2:0] detected_dim_rate;
	} ldrb_diag_t;
	typedef struct packed {
		logic [11:0] drive_current;
		logic [1:0] brt_source;
		logic [2:0] slope_sel;
		logic adv_slope;
		logic [2:0] dither_sel;
		logic [1:0] spread_range;
		logic [1:0] spread_mod;
		logic spread_pseudo;
	} ldrb_cfg_t;
	typedef struct packed {
		ldrb_i2c_st_t st;
		logic pscl;
		logic psda;
		logic [7:0] sh;
		logic [3:0] bitc;
		logic [1:0] nb;
		logic rw;
		logic [7:0] ptr;
		logic [7:0] hi;
		logic [15:0] tx;
		logic oe;
		logic [15:0] brt;
		logic [15:0] cur;
		logic [15:0] usa;
		logic [15:0] usb;
		ldrb_fault_t en;
		ldrb_fault_t flags;
		logic [15:0] bval;
		logic alert;
	} ldrb_regs_q_t;
endpackage

//--- rtl/ldrb_sync.sv
`timescale 1ns/100ps
module ldrb_sync #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] f;
	} ldrb_sync_q_t;
	ldrb_sync_q_t q, d;
	// A change is taken only once stages two and three agree
	always_comb begin
		d = q;
		d.s1 = pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.f = (q.s2 & ~(q.s2 ^ q.s3)) | (q.f & (q.s2 ^ q.s3));
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
		end else if (clk_en) begin
			q <= d;
		end
	end
	assign level = q.f;
endmodule

//--- rtl/ldrb_duty_meter.sv
`timescale 1ns/100ps
module ldrb_duty_meter #(
	parameter int WIN = 65536
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic pwm_in,
	output logic [15:0] duty
);
	localparam int WW = $clog2(WIN);
	typedef struct packed {
		logic [WW-1:0] win;
		logic [WW:0] hi;
		logic [15:0] duty;
	} ldrb_duty_q_t;
	ldrb_duty_q_t q, d;
	logic pwm_lvl;
	logic [WW+16:0] scaled;
	logic [WW:0] tot;
	ldrb_sync #(.W(1)) u_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.pin(pwm_in),
		.level(pwm_lvl)
	);
	// ----------------------------------------
	// High time over a fixed window; WIN must be a power of two
	// ----------------------------------------
	always_comb begin
		d = q;
		// The last sample of a window must count, or a steady high pin reads short of full scale
		tot = q.hi + (WW + 1)'(pwm_lvl);
		scaled = {tot, 16'h0000} >> WW;
		d.win = q.win + 1'b1;
		d.hi = tot;
		if (q.win == (WW)'(WIN - 1)) begin
			d.hi = '0;
			d.duty = (|scaled[WW+16:16]) ? 16'hFFFF : scaled[15:0];
		end
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
		end else if (clk_en) begin
			q <= d;
		end
	end
	assign duty = q.duty;
endmodule

//--- rtl/ldrb_regs.sv
`timescale 1ns/100ps
`include "ldrb_params.svh"
// How it works
// - Runs from pins alone; registers reset to usable defaults, brightness from PWM pin.
// - Register writes are accepted in every operating state, never gated.
// - Fault-alert pin is driven low while any enabled fault flag is set and the global disable bit is clear.
// - Faults latch into supply, converter and string flag registers, status plus clear.
// - A flag clears only when its status and clear bits are both written 1.
// - Each fault has a two-bit alert enable that reads 2'b10 when enabled.
// - Writing 2'b01 disables a fault's alert, 2'b11 enables it, others keep it.
// - Most alert enables come out of reset enabled.
// - A global disable bit blocks every fault from the alert pin.
// - The live state machine state is readable.
// - Measured PWM input duty is readable as 16 bits.
// - The 16-bit output PWM duty is readable.
// - The 12-bit LED current DAC code is readable.
// - The 10-bit adaptive boost target is readable.
// - Resistor-detected mode, phase, switch rate and dim rate are readable.
// - Configuration selects brightness from the PWM pin or the brightness register.
// - Configuration holds a dither selector for extra dimming resolution.
// - Configuration holds spread range, spread modulation rate and pseudo-random enable.
// - Configuration holds slope duration and the smoothing sloper enable.
// - Write: address+W, register address, data high byte, data low byte.
// - Read: address+W, register address, repeated start, address+R, two data bytes.
// - Answers slave address 0x2A or 0x2B, picked by the mode strap.
module ldrb_regs #(
	parameter int DUTY_WIN = `LDRB_DUTY_WIN
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_sel,
	input wire logic pwm_in,
	input wire ldrb_pkg::ldrb_fault_t fault_ev,
	input wire ldrb_pkg::ldrb_diag_t diag,
	output ldrb_pkg::ldrb_cfg_t cfg,
	output logic [15:0] brightness_value,
	output logic alert_n
);
	ldrb_pkg::ldrb_regs_q_t q, d;
	logic [1:0] pins;
	logic scl, sda;
	logic [15:0] in_duty;
	logic [15:0] rdata;
	logic scl_r, scl_f, start, stop;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] en_wr(input logic [7:0] cur, input logic [15:0] w);
		logic [7:0] r;
		r = cur;
		for (int k = 0; k < 8; k++) begin
			if (w[2*k+:2] == `LDRB_EN_DIS) begin
				r[k] = 1'b0;
			end else if (w[2*k+:2] == `LDRB_EN_ENA) begin
				r[k] = 1'b1;
			end
		end
		return r;
	endfunction
	function automatic logic [15:0] en_rd(input logic [7:0] en);
		logic [15:0] r;
		r = '0;
		for (int k = 0; k < 8; k++) begin
			r[2*k+:2] = en[k] ? `LDRB_EN_RD_ON : 2'h0;
		end
		return r;
	endfunction
	function automatic logic [7:0] clr_mask(input logic [15:0] w);
		logic [7:0] r;
		r = '0;
		for (int k = 0; k < 8; k++) begin
			r[k] = w[2*k] & w[2*k+1];
		end
		return r;
	endfunction
	function automatic logic [15:0] st_rd(input logic [7:0] st);
		logic [15:0] r;
		r = '0;
		for (int k = 0; k < 8; k++) begin
			r[2*k] = st[k];
		end
		return r;
	endfunction
	// ----------------------------------------
	// Pin conditioning and PWM input meter
	// ----------------------------------------
	ldrb_sync #(.W(2)) u_i2c_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.pin({scl_in, sda_in}),
		.level(pins)
	);
	assign scl = pins[1];
	assign sda = pins[0];
	ldrb_duty_meter #(.WIN(DUTY_WIN)) u_meter (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.pwm_in(pwm_in),
		.duty(in_duty)
	);
	assign scl_r = scl & ~q.pscl;
	assign scl_f = ~scl & q.pscl;
	assign start = scl & q.pscl & q.psda & ~sda;
	assign stop = scl & q.pscl & ~q.psda & sda;
	// ----------------------------------------
	// Read multiplexer
	// ----------------------------------------
	always_comb begin
		rdata = 16'h0000;
		unique case (q.ptr)
			`LDRB_OFF_BRT: rdata = q.brt;
			`LDRB_OFF_CUR: rdata = q.cur;
			`LDRB_OFF_USA: rdata = q.usa;
			`LDRB_OFF_USB: rdata = q.usb;
			`LDRB_OFF_EN_SUP: rdata = en_rd(q.en.sup);
			`LDRB_OFF_EN_CNV: rdata = en_rd(q.en.cnv);
			`LDRB_OFF_EN_STR: rdata = en_rd(q.en.str);
			`LDRB_OFF_ST_SUP: rdata = st_rd(q.flags.sup);
			`LDRB_OFF_ST_CNV: rdata = st_rd(q.flags.cnv);
			`LDRB_OFF_ST_STR: rdata = st_rd(q.flags.str);
			`LDRB_OFF_STATE: rdata = diag.live_state_readback;
			`LDRB_OFF_IN_DUTY: rdata = in_duty;
			`LDRB_OFF_OUT_DUTY: rdata = diag.output_duty_readback;
			`LDRB_OFF_CUR_CODE: rdata = {4'h0, diag.current_code_readback};
			`LDRB_OFF_BOOST: rdata = {6'h00, diag.boost_target_readback};
			`LDRB_OFF_DETECT: begin
				rdata = {4'h0, diag.detected_dim_rate, diag.detected_switch_rate,
					diag.detected_phase_setting, diag.detected_dim_mode};
			end
			default: rdata = 16'h0000;
		endcase
	end
	// ----------------------------------------
	// Serial slave and register file
	// ----------------------------------------
	always_comb begin
		logic wv;
		logic [7:0] wa;
		logic [15:0] wd;
		logic [15:0] t;
		logic hit;
		wv = 1'b0;
		wa = q.ptr;
		wd = {q.hi, q.sh};
		t = q.tx << 1;
		hit = q.sh[7:1] == {`LDRB_SLV_BASE, addr_sel};
		d = q;
		d.pscl = scl;
		d.psda = sda;
		if (start) begin
			d.st = ldrb_pkg::I_ADDR;
			d.bitc = 4'h0;
			d.oe = 1'b0;
		end else if (stop) begin
			d.st = ldrb_pkg::I_IDLE;
			d.oe = 1'b0;
		end else begin
			unique case (q.st)
				ldrb_pkg::I_IDLE: begin
					d.oe = 1'b0;
				end
				ldrb_pkg::I_ADDR, ldrb_pkg::I_RX: begin
					if (scl_r && q.bitc < 4'h8) begin
						d.sh = {q.sh[6:0], sda};
						d.bitc = q.bitc + 4'h1;
					end else if (scl_f && q.bitc == 4'h8) begin
						d.st = ldrb_pkg::I_ACK;
						d.oe = 1'b1;
						if (q.st == ldrb_pkg::I_ADDR) begin
							d.rw = q.sh[0];
							d.nb = 2'h0;
							d.tx = rdata;
							if (!hit) begin
								d.st = ldrb_pkg::I_IDLE;
								d.oe = 1'b0;
							end
						end else begin
							d.nb = (q.nb == 2'h3) ? q.nb : q.nb + 2'h1;
							unique case (q.nb)
								2'h0: d.ptr = q.sh;
								2'h1: d.hi = q.sh;
								2'h2: wv = 1'b1;
								2'h3: begin
									// Bytes past the fourth are refused
									d.st = ldrb_pkg::I_IDLE;
									d.oe = 1'b0;
								end
							endcase
						end
					end
				end
				ldrb_pkg::I_ACK: begin
					if (scl_f) begin
						d.bitc = 4'h0;
						if (q.rw) begin
							d.st = ldrb_pkg::I_TX;
							d.oe = ~q.tx[15];
						end else begin
							d.st = ldrb_pkg::I_RX;
							d.oe = 1'b0;
						end
					end
				end
				ldrb_pkg::I_TX: begin
					if (scl_f) begin
						d.tx = t;
						d.bitc = q.bitc + 4'h1;
						if (q.bitc == 4'h7) begin
							d.st = ldrb_pkg::I_RACK;
							d.oe = 1'b0;
						end else begin
							d.oe = ~t[15];
						end
					end
				end
				ldrb_pkg::I_RACK: begin
					if (scl_r && sda) begin
						// Host said no more: let go of the line
						d.st = ldrb_pkg::I_IDLE;
					end else if (scl_f) begin
						d.st = ldrb_pkg::I_TX;
						d.bitc = 4'h0;
						d.oe = ~q.tx[15];
					end
				end
			endcase
		end
		// Fault flags: a new event beats a clear in the same cycle
		d.flags.sup = q.flags.sup | fault_ev.sup;
		d.flags.cnv = q.flags.cnv | fault_ev.cnv;
		d.flags.str = q.flags.str | fault_ev.str;
		if (wv) begin
			unique case (wa)
				`LDRB_OFF_BRT: d.brt = wd;
				`LDRB_OFF_CUR: d.cur = wd;
				`LDRB_OFF_USA: d.usa = wd;
				`LDRB_OFF_USB: d.usb = wd;
				`LDRB_OFF_EN_SUP: d.en.sup = en_wr(q.en.sup, wd);
				`LDRB_OFF_EN_CNV: d.en.cnv = en_wr(q.en.cnv, wd);
				`LDRB_OFF_EN_STR: d.en.str = en_wr(q.en.str, wd);
				`LDRB_OFF_ST_SUP: begin
					d.flags.sup = (q.flags.sup & ~clr_mask(wd)) | fault_ev.sup;
				end
				`LDRB_OFF_ST_CNV: begin
					d.flags.cnv = (q.flags.cnv & ~clr_mask(wd)) | fault_ev.cnv;
				end
				`LDRB_OFF_ST_STR: begin
					d.flags.str = (q.flags.str & ~clr_mask(wd)) | fault_ev.str;
				end
				default: d.hi = q.hi;
			endcase
		end
		// Alert follows the stored flags one cycle later
		d.alert = ~q.usb[`LDRB_GDIS_BIT] &
			|({q.flags.sup, q.flags.cnv, q.flags.str} &
			{q.en.sup, q.en.cnv, q.en.str});
		// Pin duty is the source unless software took over brightness
		d.bval = (q.usa[9:8] == `LDRB_SRC_REG) ? q.brt : in_duty;
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
			q.st <= ldrb_pkg::I_IDLE;
			q.pscl <= 1'b1;
			q.psda <= 1'b1;
			q.brt <= `LDRB_RST_BRT;
			q.cur <= `LDRB_RST_CUR;
			q.usa <= `LDRB_RST_USA;
			q.usb <= `LDRB_RST_USB;
			q.en.sup <= `LDRB_RST_EN_SUP;
			q.en.cnv <= `LDRB_RST_EN_CNV;
			q.en.str <= `LDRB_RST_EN_STR;
		end else if (clk_en) begin
			q <= d;
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign sda_out = 1'b0;
	assign sda_oe = q.oe;
	assign alert_n = ~q.alert;
	assign brightness_value = q.bval;
	assign cfg.drive_current = q.cur[11:0];
	assign cfg.brt_source = q.usa[9:8];
	assign cfg.slope_sel = q.usa[7:5];
	assign cfg.adv_slope = q.usa[1];
	assign cfg.dither_sel = q.usa[4:2];
	assign cfg.spread_range = q.usa[11:10];
	assign cfg.spread_mod = q.usa[13:12];
	assign cfg.spread_pseudo = q.usa[14];
endmodule

//--- tb/ldrb_regs_properties.sv
`timescale 1ns/100ps
module ldrb_regs_properties #(
	parameter int DUTY_WIN = 65536
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic addr_sel,
	input wire logic pwm_in,
	input wire ldrb_pkg::ldrb_fault_t fault_ev,
	input wire ldrb_pkg::ldrb_diag_t diag,
	input wire ldrb_pkg::ldrb_cfg_t cfg,
	input wire logic [15:0] brightness_value,
	input wire logic alert_n
);
	// ----------------------------------------
	// Port relations
	// ----------------------------------------
	localparam logic [34:0] CFG_RST = {12'hFFF, 2'h0, 3'h5, 1'b1, 3'h0, 2'h2, 2'h0, 1'b0};
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	chk_drain_only: assert property (sda_out == 1'b0)
		else $error("sda_out driven high");
	chk_reset_state: assert property ($fell(sys_rst) |->
		alert_n && !sda_oe && cfg == CFG_RST && brightness_value == 16'h0000)
		else $error("outputs not at reset values");
	// Host holds SCL low at least 8 clocks, so any bus-made change lands inside that span
	chk_cfg_by_bus: assert property (!$stable(cfg) |-> !scl_in && !$past(scl_in, 3))
		else $error("cfg changed outside a bus write");
	chk_oe_scl_low: assert property (!$stable(sda_oe) |-> !scl_in)
		else $error("sda_oe changed while SCL high");
	chk_ack_hold: assert property ($rose(sda_oe) |-> !scl_in ##1 !scl_in)
		else $error("sda_oe raised late in the low phase");
	chk_alert_cause: assert property ($fell(alert_n) |-> $past(fault_ev, 2) != '0 || !scl_in)
		else $error("alert asserted without a fault or a write");
	chk_alert_clear: assert property ($rose(alert_n) |-> !scl_in)
		else $error("alert released without a write");
	chk_brt_hold: assert property (cfg.brt_source == 2'h2 && !$stable(brightness_value) |-> !scl_in)
		else $error("register brightness changed without a write");
	cov_alert: cover property (!alert_n);
	cov_ack: cover property ($rose(sda_oe));
	cov_reg_src: cover property (cfg.brt_source == 2'h2);
endmodule

bind ldrb_regs ldrb_regs_properties #(.DUTY_WIN(DUTY_WIN)) ldrb_regs_properties_i (
	.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
	.pwm_in(pwm_in), .fault_ev(fault_ev), .diag(diag), .cfg(cfg),
	.brightness_value(brightness_value), .alert_n(alert_n)
);

//--- tb/ldrb_host_model.sv
`timescale 1ns/100ps
module ldrb_host_model #(
	parameter logic WR_BIT = 1'b0
) (
	input wire logic core_clk,
	input wire logic dev_oe,
	input wire logic dev_out,
	output logic scl,
	output logic sda
);
	// ----------------------------------------
	// Two-wire host
	// ----------------------------------------
	logic pull_q = 1'b0;
	// Open drain with pull-up: a released line reads high
	assign sda = !(pull_q || (dev_oe && !dev_out));
	initial scl = 1'b1;
	task automatic w(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Data moves 10 clocks after SCL falls, clear of the device's input filter
	task automatic bit_x(input logic b, output logic r);
		pull_q = !b;
		w(10);
		scl = 1'b1;
		w(10);
		r = sda;
		scl = 1'b0;
		w(10);
	endtask
	task automatic start();
		pull_q = 1'b0;
		w(10);
		scl = 1'b1;
		w(10);
		pull_q = 1'b1;
		w(10);
		scl = 1'b0;
		w(10);
	endtask
	task automatic stop();
		pull_q = 1'b1;
		w(10);
		scl = 1'b1;
		w(10);
		pull_q = 1'b0;
		w(10);
	endtask
	task automatic xfer(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			bit_x(d[i], r[i]);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] g, input logic [15:0] v,
		output logic [3:0] k);
		logic [8:0] r0, r1, r2, r3;
		start();
		xfer({a, WR_BIT, 1'b1}, r0);
		xfer({g, 1'b1}, r1);
		xfer({v[15:8], 1'b1}, r2);
		xfer({v[7:0], 1'b1}, r3);
		stop();
		k = {r0[0], r1[0], r2[0], r3[0]};
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] g, output logic [15:0] v,
		output logic [2:0] k);
		logic [8:0] r0, r1, r2, r3, r4;
		start();
		xfer({a, WR_BIT, 1'b1}, r0);
		xfer({g, 1'b1}, r1);
		start();
		xfer({a, !WR_BIT, 1'b1}, r2);
		xfer(9'h1FE, r3);
		xfer(9'h1FF, r4);
		stop();
		v = {r3[8:1], r4[8:1]};
		k = {r0[0], r1[0], r2[0]};
	endtask
endmodule

//--- tb/test_ldrb_regs.sv
`timescale 1ns/100ps
module test_ldrb_regs;
	// ----------------------------------------
	// Bench
	// ----------------------------------------
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic addr_sel = 1'b0;
	logic clk_en = 1'b1;
	logic pwm_in = 1'b1;
	logic scl, sda, sda_out, sda_oe, alert_n;
	logic [15:0] brightness_value, v;
	logic [3:0] ak;
	ldrb_pkg::ldrb_fault_t fault_ev = '0;
	ldrb_pkg::ldrb_diag_t diag = {16'hA5C3, 16'h1357, 12'hABC, 10'h2F1, 3'h5, 3'h2, 3'h6, 3'h1};
	ldrb_pkg::ldrb_cfg_t cfg;
	int fail_count = 0;
	int checks_done = 0;
	logic [7:0] offs [14] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C,
		8'h0E, 8'h14, 8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h16};
	logic [15:0] rvals [14] = '{16'h0000, 16'h0FFF, 16'h08A3, 16'h0000, 16'hAAAA, 16'hAAAA,
		16'h2AAA, 16'h0000, 16'hA5C3, 16'h1357, 16'h0ABC, 16'h02F1, 16'h0395, 16'hFFFF};
	always #25 core_clk = ~core_clk;
	ldrb_regs #(.DUTY_WIN(256)) ldrb_regs_i (.core_clk(core_clk), .sys_rst(sys_rst),
		.clk_en(clk_en), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.addr_sel(addr_sel), .pwm_in(pwm_in), .fault_ev(fault_ev), .diag(diag), .cfg(cfg),
		.brightness_value(brightness_value), .alert_n(alert_n));
	ldrb_host_model ldrb_host_model_i (.core_clk(core_clk), .dev_oe(sda_oe),
		.dev_out(sda_out), .scl(scl), .sda(sda));
	task automatic chk(input string nm, input logic [35:0] s, input logic [35:0] e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic rdc(input logic [7:0] r, input logic [15:0] e);
		ldrb_host_model_i.rd(7'h2A, r, v, ak[2:0]);
		chk($sformatf("reg %h", r), v, e);
		chk("read acks", ak[2:0], 3'h0);
	endtask
	task automatic wrc(input logic [7:0] r, input logic [15:0] d);
		ldrb_host_model_i.wr(7'h2A, r, d, ak);
		chk("write acks", ak, 4'h0);
	endtask
	// Fault event lasts one cycle, then the alert has had time to settle
	task automatic ev(input logic [23:0] f);
		fault_ev = f;
		ldrb_host_model_i.w(1);
		fault_ev = '0;
		ldrb_host_model_i.w(3);
	endtask
	task automatic report_and_stop();
		if (fail_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#5000000;
		fail_count++;
		report_and_stop();
	end
	initial begin
		ldrb_host_model_i.w(10);
		sys_rst = 1'b0;
		ldrb_host_model_i.w(6);
		chk("cfg", cfg, {12'hFFF, 2'h0, 3'h5, 1'b1, 3'h0, 2'h2, 2'h0, 1'b0});
		for (int i = 0; i < 14; i++) begin
			rdc(offs[i], rvals[i]);
		end
		chk("bright", brightness_value, 16'hFFFF);
		wrc(8'h00, 16'h1234);
		wrc(8'h02, 16'hF123);
		wrc(8'h04, 16'h7A6D);
		chk("cfg", cfg, {12'h123, 2'h2, 3'h3, 1'b0, 3'h3, 2'h2, 2'h3, 1'b1});
		chk("bright", brightness_value, 16'h1234);
		rdc(8'h02, 16'hF123);
		ev(24'h000080);
		chk("alert", alert_n, 1'b1);
		ev(24'h010000);
		chk("alert", alert_n, 1'b0);
		rdc(8'h12, 16'h4000);
		wrc(8'h0E, 16'h0001);
		wrc(8'h0E, 16'h0002);
		rdc(8'h0E, 16'h0001);
		chk("alert", alert_n, 1'b0);
		wrc(8'h08, 16'h0001);
		rdc(8'h08, 16'hAAA8);
		chk("alert", alert_n, 1'b1);
		wrc(8'h08, 16'h0003);
		chk("alert", alert_n, 1'b0);
		wrc(8'h06, 16'h0001);
		chk("alert", alert_n, 1'b1);
		ev(24'h020000);
		chk("alert", alert_n, 1'b1);
		wrc(8'h06, 16'h0000);
		chk("alert", alert_n, 1'b0);
		wrc(8'h0A, 16'h0000);
		rdc(8'h0A, 16'hAAAA);
		wrc(8'h0E, 16'h000F);
		rdc(8'h0E, 16'h0000);
		chk("alert", alert_n, 1'b1);
		ldrb_host_model_i.wr(7'h2B, 8'h00, 16'h5555, ak);
		chk("wrong address ack", ak[3], 1'b1);
		addr_sel = 1'b1;
		ldrb_host_model_i.wr(7'h2B, 8'h20, 16'h5555, ak);
		chk("strap address acks", ak, 4'h0);
		ldrb_host_model_i.wr(7'h2B, 8'h14, 16'h5555, ak);
		addr_sel = 1'b0;
		// With the clock enable low the whole frame must pass unseen
		clk_en = 1'b0;
		ldrb_host_model_i.wr(7'h2A, 8'h00, 16'hBEEF, ak);
		clk_en = 1'b1;
		ldrb_host_model_i.w(4);
		chk("frozen acks", ak, 4'hF);
		rdc(8'h20, 16'h0000);
		rdc(8'h14, 16'hA5C3);
		rdc(8'h00, 16'h1234);
		report_and_stop();
	end
endmodule
